/* File: pkg/t2rc_pkg.sv */
// Purpose: Constants for the reload/capture timer with an APB register port.
// Assumes: 32-bit APB data, one register per aligned word, byte address = 4 * index.
// Notes:   Overview follows.
// Overview of operation
// - Split bit low makes the two count bytes one 16-bit up-counter.
// - 16-bit rollover from 0xFFFF reloads the reload pair and sets the high flag.
// - With the timer interrupt enabled, every 16-bit overflow requests an interrupt.
// - In 16-bit mode the low-byte enable adds a request per low-byte rollover.
// - Count source is system clock, system clock over 12, or external over 8.
// - External clock over 8 is synchronised to the system clock before use.
// - Split bit high makes two 8-bit counters, each auto-reloading on rollover.
// - Low reload byte feeds the low counter, high reload byte the high one.
// - In split mode run control gates the high counter only; low always runs.
// - Per-half select: 1 is system clock, 0 follows the external clock select.
// - High flag sets whenever the high count byte rolls over from 0xFF.
// - Low flag sets whenever the low count byte rolls over, in every mode.
// - Split mode requests on high overflow; low-byte enable adds low overflow.
// - Hardware never clears the overflow flags; software clears and inspects both.
// - Capture enable with capture source select set enters capture mode.
// - 16-bit capture runs freely and copies the count into the reload pair.
// - Split capture runs two free 8-bit counters; both bytes copied on capture.
// - Capture event is a falling oscillator edge; it raises an interrupt if enabled.
// - Control bits are individually settable and clearable; all reset to zero.
// - Counting needs run control high, except the split-mode low counter.
// - External clock select picks system clock over 12 or external over 8.
package t2rc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL   = 8'hc8;
  localparam logic [7:0] IDX_RELOAD_LO = 8'hca;
  localparam logic [7:0] IDX_RELOAD_HI = 8'hcb;
  localparam logic [7:0] IDX_COUNT_LO  = 8'hcc;
  localparam logic [7:0] IDX_COUNT_HI  = 8'hcd;
  localparam logic [7:0] IDX_CLK_IRQ   = 8'hd0;
  localparam logic [7:0] IDX_BIT_OP    = 8'hd1;

  // Control register fields
  localparam int BIT_HI_FLAG  = 7;
  localparam int BIT_LO_FLAG  = 6;
  localparam int BIT_LO_IRQEN = 5;
  localparam int BIT_CAP_EN   = 4;
  localparam int BIT_SPLIT    = 3;
  localparam int BIT_RUN      = 2;
  localparam int BIT_CAP_SRC  = 1;
  localparam int BIT_EXT_SEL  = 0;

  // Clock/interrupt register fields
  localparam int BIT_LO_CLKSEL = 0;
  localparam int BIT_HI_CLKSEL = 1;
  localparam int BIT_TIMER_IE  = 2;

  // Bit-operation register fields
  localparam int BITOP_VALUE = 3;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [2:0] CLK_IRQ_RESET = 3'h0;

  // Timing
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;

endpackage

/* File: design/t2rc_timer.sv */
// Purpose: 16-bit / dual 8-bit auto-reload timer with oscillator capture, APB slave.
// Assumes: One clock clk_sys, synchronous active-low reset, pins asynchronous.
// Notes:   APB answers after one wait state; unmapped addresses give pslverr.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

module t2rc_timer #(
  parameter int SYS_DIV = t2rc_pkg::SYS_DIV,
  parameter int EXT_DIV = t2rc_pkg::EXT_DIV
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        ext_osc_clk,
  input  wire logic        low_frequency_oscillator,
  // Interrupt request
  output logic             timer_irq
);

  if (SYS_DIV < 2 || SYS_DIV > 256) begin : g_chk_sys
    $error("SYS_DIV out of range");
  end
  if (EXT_DIV < 2 || EXT_DIV > 256) begin : g_chk_ext
    $error("EXT_DIV out of range");
  end

  // Registers
  logic [7:0]  timer_two_control_ff;
  logic [7:0]  count_low_byte_ff;
  logic [7:0]  count_high_byte_ff;
  logic [7:0]  reload_low_byte_ff;
  logic [7:0]  reload_high_byte_ff;
  logic [2:0]  clk_irq_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_ff;

  // Pin synchronisers, three stages each
  logic [2:0]  sync_ff [2];
  logic [1:0]  pin_in;
  logic [1:0]  pin_lvl_ff;

  // Dividers and edge tracking
  logic [7:0]  sys_div_ff;
  logic [7:0]  ext_div_ff;
  logic        sys_tick;
  logic        ext_tick;
  logic        ext_rise;
  logic        osc_fall;

  // Decoded control
  logic        hi_flag;
  logic        lo_flag;
  logic        lo_irqen;
  logic        split_mode_bit;
  logic        run_control_bit;
  logic        external_clock_select;
  logic        cap_mode;
  logic        low_half_clock_select;
  logic        high_half_clock_select;
  logic        timer_irq_enable;
  logic        slow_tick;
  logic        lo_tick;
  logic        hi_tick;

  // Next-state of counter
  logic [7:0]  nxt_count_lo;
  logic [7:0]  nxt_count_hi;
  logic        set_hi;
  logic        set_lo;

  // Bus decode
  logic [7:0]  idx;
  logic        mapped;
  logic        acc;
  logic        wr_en;
  logic        nxt_pready;
  logic [7:0]  rd_byte;
  logic [2:0]  nxt_clk_irq;
  logic [7:0]  nxt_control;
  logic [2:0]  bitop_sel;

  assign pin_in = {low_frequency_oscillator, ext_osc_clk};

  // Only stage 1 reads stage 0; edges use stages 1 and 2 once they agree
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        sync_ff[i]    <= 3'h0;
        pin_lvl_ff[i] <= 1'b0;
      end else begin
        sync_ff[i] <= {sync_ff[i][1:0], pin_in[i]};
        if (sync_ff[i][1] == sync_ff[i][2]) begin
          pin_lvl_ff[i] <= sync_ff[i][2];
        end
      end
    end
  end

  assign ext_rise = (sync_ff[0][1] == sync_ff[0][2]) && sync_ff[0][2] && !pin_lvl_ff[0];
  assign osc_fall = (sync_ff[1][1] == sync_ff[1][2]) && !sync_ff[1][2] && pin_lvl_ff[1];

  assign hi_flag                = timer_two_control_ff[t2rc_pkg::BIT_HI_FLAG];
  assign lo_flag                = timer_two_control_ff[t2rc_pkg::BIT_LO_FLAG];
  assign lo_irqen               = timer_two_control_ff[t2rc_pkg::BIT_LO_IRQEN];
  assign split_mode_bit         = timer_two_control_ff[t2rc_pkg::BIT_SPLIT];
  assign run_control_bit        = timer_two_control_ff[t2rc_pkg::BIT_RUN];
  assign external_clock_select  = timer_two_control_ff[t2rc_pkg::BIT_EXT_SEL];
  assign low_half_clock_select  = clk_irq_ff[t2rc_pkg::BIT_LO_CLKSEL];
  assign high_half_clock_select = clk_irq_ff[t2rc_pkg::BIT_HI_CLKSEL];
  assign timer_irq_enable       = clk_irq_ff[t2rc_pkg::BIT_TIMER_IE];

  // Capture needs both the enable and the oscillator source
  assign cap_mode = timer_two_control_ff[t2rc_pkg::BIT_CAP_EN] &&
                    timer_two_control_ff[t2rc_pkg::BIT_CAP_SRC];

  // System clock divider; free running so the tick rate is steady
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sys_div_ff <= 8'h00;
    end else if (sys_div_ff == 8'(SYS_DIV - 1)) begin
      sys_div_ff <= 8'h00;
    end else begin
      sys_div_ff <= sys_div_ff + 8'h01;
    end
  end
  assign sys_tick = (sys_div_ff == 8'(SYS_DIV - 1));

  // External clock divider, counts synchronised rising edges
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ext_div_ff <= 8'h00;
    end else if (ext_rise) begin
      if (ext_div_ff == 8'(EXT_DIV - 1)) begin
        ext_div_ff <= 8'h00;
      end else begin
        ext_div_ff <= ext_div_ff + 8'h01;
      end
    end
  end
  assign ext_tick = ext_rise && (ext_div_ff == 8'(EXT_DIV - 1));

  assign slow_tick = external_clock_select ? ext_tick : sys_tick;
  assign lo_tick   = low_half_clock_select ? 1'b1 : slow_tick;
  assign hi_tick   = high_half_clock_select ? 1'b1 : slow_tick;

  // Counter next value
  always_comb begin
    nxt_count_lo = count_low_byte_ff;
    nxt_count_hi = count_high_byte_ff;
    set_hi       = 1'b0;
    set_lo       = 1'b0;
    if (split_mode_bit) begin
      // Low half ignores run control in split mode
      if (lo_tick) begin
        if (count_low_byte_ff == 8'hff) begin
          set_lo       = 1'b1;
          nxt_count_lo = cap_mode ? 8'h00 : reload_low_byte_ff;
        end else begin
          nxt_count_lo = count_low_byte_ff + 8'h01;
        end
      end
      if (run_control_bit && hi_tick) begin
        if (count_high_byte_ff == 8'hff) begin
          set_hi       = 1'b1;
          nxt_count_hi = cap_mode ? 8'h00 : reload_high_byte_ff;
        end else begin
          nxt_count_hi = count_high_byte_ff + 8'h01;
        end
      end
    end else if (run_control_bit && lo_tick) begin
      if (count_low_byte_ff == 8'hff) begin
        set_lo = 1'b1;
        if (count_high_byte_ff == 8'hff) begin
          set_hi = 1'b1;
          // Capture mode rolls to zero; the reload pair then holds captures
          nxt_count_lo = cap_mode ? 8'h00 : reload_low_byte_ff;
          nxt_count_hi = cap_mode ? 8'h00 : reload_high_byte_ff;
        end else begin
          nxt_count_lo = 8'h00;
          nxt_count_hi = count_high_byte_ff + 8'h01;
        end
      end else begin
        nxt_count_lo = count_low_byte_ff + 8'h01;
      end
    end
  end

  // APB decode; one wait state keeps read data registered
  assign idx        = paddr[9:2];
  assign mapped     = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                      (idx == t2rc_pkg::IDX_CONTROL   || idx == t2rc_pkg::IDX_RELOAD_LO ||
                       idx == t2rc_pkg::IDX_RELOAD_HI || idx == t2rc_pkg::IDX_COUNT_LO  ||
                       idx == t2rc_pkg::IDX_COUNT_HI  || idx == t2rc_pkg::IDX_CLK_IRQ   ||
                       idx == t2rc_pkg::IDX_BIT_OP);
  assign acc        = psel && penable;
  assign nxt_pready = acc && !pready_ff;
  assign wr_en      = acc && pready_ff && pwrite && mapped && pstrb[0];
  assign bitop_sel  = pwdata[2:0];

  always_comb begin
    case (idx)
      t2rc_pkg::IDX_CONTROL:   rd_byte = timer_two_control_ff;
      t2rc_pkg::IDX_RELOAD_LO: rd_byte = reload_low_byte_ff;
      t2rc_pkg::IDX_RELOAD_HI: rd_byte = reload_high_byte_ff;
      t2rc_pkg::IDX_COUNT_LO:  rd_byte = count_low_byte_ff;
      t2rc_pkg::IDX_COUNT_HI:  rd_byte = count_high_byte_ff;
      t2rc_pkg::IDX_CLK_IRQ:   rd_byte = {5'h00, clk_irq_ff};
      default:                 rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pready && !mapped;
      if (nxt_pready && !pwrite) begin
        prdata_ff <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // Control register; full write or single-bit operation
  always_comb begin
    nxt_control = timer_two_control_ff;
    if (wr_en && idx == t2rc_pkg::IDX_CONTROL) begin
      nxt_control = pwdata[7:0];
    end else if (wr_en && idx == t2rc_pkg::IDX_BIT_OP) begin
      nxt_control[bitop_sel] = pwdata[t2rc_pkg::BITOP_VALUE];
    end
    // Hardware set beats a same-cycle software clear; never cleared here
    if (set_hi || (cap_mode && osc_fall)) begin
      nxt_control[t2rc_pkg::BIT_HI_FLAG] = 1'b1;
    end
    if (set_lo) begin
      nxt_control[t2rc_pkg::BIT_LO_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      timer_two_control_ff <= t2rc_pkg::CONTROL_RESET;
    end else begin
      timer_two_control_ff <= nxt_control;
    end
  end

  assign nxt_clk_irq = (wr_en && idx == t2rc_pkg::IDX_CLK_IRQ) ? pwdata[2:0] : clk_irq_ff;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      clk_irq_ff <= t2rc_pkg::CLK_IRQ_RESET;
    end else begin
      clk_irq_ff <= nxt_clk_irq;
    end
  end

  // Count bytes; software write wins
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      count_low_byte_ff  <= t2rc_pkg::BYTE_RESET;
      count_high_byte_ff <= t2rc_pkg::BYTE_RESET;
    end else begin
      if (wr_en && idx == t2rc_pkg::IDX_COUNT_LO) begin
        count_low_byte_ff <= pwdata[7:0];
      end else begin
        count_low_byte_ff <= nxt_count_lo;
      end
      if (wr_en && idx == t2rc_pkg::IDX_COUNT_HI) begin
        count_high_byte_ff <= pwdata[7:0];
      end else begin
        count_high_byte_ff <= nxt_count_hi;
      end
    end
  end

  // Reload bytes; capture copies the count present at the event
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reload_low_byte_ff  <= t2rc_pkg::BYTE_RESET;
      reload_high_byte_ff <= t2rc_pkg::BYTE_RESET;
    end else begin
      if (wr_en && idx == t2rc_pkg::IDX_RELOAD_LO) begin
        reload_low_byte_ff <= pwdata[7:0];
      end else if (cap_mode && osc_fall) begin
        reload_low_byte_ff <= count_low_byte_ff;
      end
      if (wr_en && idx == t2rc_pkg::IDX_RELOAD_HI) begin
        reload_high_byte_ff <= pwdata[7:0];
      end else if (cap_mode && osc_fall) begin
        reload_high_byte_ff <= count_high_byte_ff;
      end
    end
  end

  // Request is a level held while a flag that may interrupt stays set
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= timer_irq_enable && (nxt_control[t2rc_pkg::BIT_HI_FLAG] ||
                (nxt_control[t2rc_pkg::BIT_LO_IRQEN] &&
                 nxt_control[t2rc_pkg::BIT_LO_FLAG]));
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign timer_irq = irq_ff;

endmodule

/* File: dv/t2rc_timer_monitor.sv */
// Purpose: Port-level checks for the reload/capture timer.
// Assumes: Bound to t2rc_timer; one clock, synchronous active-low reset.
// Notes:   Timer modes are judged by the bench; only port relations here.
`timescale 1ns/1ps
module t2rc_timer_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt
  input wire logic        timer_irq
);
  logic mapped;
  assign mapped = paddr inside {12'h320, 12'h328, 12'h32c, 12'h330, 12'h334, 12'h340, 12'h344};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_ONE_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  AST_RDATA_BYTE: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_RDATA_HOLD: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved without a read answer");
  // A flag only drops by a software write, so the request holds until one lands
  AST_IRQ_STANDS: assert property (timer_irq && !(pready && pwrite) |=> timer_irq)
    else $error("interrupt dropped without a write");
  AST_IRQ_RESET: assert property (disable iff (1'b0) !rstn |=> !timer_irq)
    else $error("interrupt active after reset");
endmodule

bind t2rc_timer t2rc_timer_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_irq(timer_irq));

/* File: dv/t2rc_timer_tb_top.sv */
// Purpose: Self-checking bench for the reload/capture timer.
// Assumes: APB master changes signals by NBA just after rising edges.
// Notes:   Count windows allow for prescaler phase and APB latency.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module t2rc_timer_tb_top;
  localparam logic [11:0] CTL = 12'h320, RLL = 12'h328, RLH = 12'h32c, CL = 12'h330;
  localparam logic [11:0] CH = 12'h334, CK = 12'h340, BO = 12'h344;
  localparam logic [11:0] MAP [7] = '{CTL, RLL, RLH, CL, CH, CK, BO};
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_osc_clk = 1'b0;
  logic        osc_low_pin = 1'b1;
  logic        timer_irq;
  logic        ext_on = 1'b0;
  logic [1:0]  ediv = 2'd0;
  logic [7:0]  rq;
  logic        re;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;

  t2rc_timer dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_osc_clk(ext_osc_clk),
    .low_frequency_oscillator(osc_low_pin), .timer_irq(timer_irq));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // External source toggles every 3 cycles, so one rising edge per 6 cycles
  always @(posedge clk_sys) begin
    ediv <= (ediv == 2'd2) ? 2'd0 : ediv + 2'd1;
    if (ext_on && ediv == 2'd2) ext_osc_clk <= ~ext_osc_clk;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Waits for pready as long as it takes; only the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd_is(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rq, e)
  endtask

  task automatic rd_in(input logic [11:0] a, input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b0, a, 8'h00);
    `CHK(rq inside {[lo:hi]}, 1'b1)
  endtask

  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    `CHK(timer_irq, e)
    @(posedge clk_sys);
  endtask

  task automatic t_reset_map;
    foreach (MAP[i]) rd_is(MAP[i], 8'h00);
    apb(1'b1, 12'h000, 8'hff);
    `CHK(re, 1'b1)
    pstrb <= 4'h0;
    apb(1'b1, CTL, 8'hff);
    pstrb <= 4'hf;
    `CHK(re, 1'b0)
    rd_is(CTL, 8'h00);
  endtask

  // Every control bit set and cleared on its own through the bit-op port
  task automatic t_bitop;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, BO, {4'h0, 1'b1, 3'(i)});
      rd_is(CTL, 8'h01 << i);
      apb(1'b1, BO, {4'h0, 1'b0, 3'(i)});
      rd_is(CTL, 8'h00);
    end
  endtask

  task automatic t_reload16;
    apb(1'b1, RLL, 8'h34);
    apb(1'b1, RLH, 8'h12);
    apb(1'b1, CL, 8'hff);
    apb(1'b1, CH, 8'hff);
    apb(1'b1, CK, 8'h05);
    apb(1'b1, CTL, 8'h04);
    rd_is(CTL, 8'hc4);
    rd_is(CH, 8'h12);
    irq_is(1'b1);
    apb(1'b1, CTL, 8'h44);
    irq_is(1'b0);
    rd_is(CTL, 8'h44);
    apb(1'b1, CTL, 8'h64);
    irq_is(1'b1);
    apb(1'b1, CTL, 8'h00);
    irq_is(1'b0);
  endtask

  task automatic t_split;
    apb(1'b1, RLL, 8'hf0);
    apb(1'b1, CL, 8'hfe);
    apb(1'b1, CH, 8'h55);
    apb(1'b1, CTL, 8'h08);
    rd_is(CTL, 8'h48);
    rd_is(CH, 8'h55);
    rd_in(CL, 8'hf0, 8'hff);
    irq_is(1'b0);
    apb(1'b1, CTL, 8'h28);
    repeat (20) @(posedge clk_sys);
    irq_is(1'b1);
    apb(1'b1, RLH, 8'h77);
    apb(1'b1, CK, 8'h07);
    apb(1'b1, CH, 8'hfd);
    apb(1'b1, CTL, 8'h0c);
    repeat (4) @(posedge clk_sys);
    rd_in(CTL, 8'h8c, 8'hcc);
    rd_in(CH, 8'h77, 8'h90);
    apb(1'b1, CTL, 8'h00);
  endtask

  task automatic t_rates;
    apb(1'b1, CK, 8'h00);
    apb(1'b1, CL, 8'h00);
    apb(1'b1, CTL, 8'h04);
    repeat (240) @(posedge clk_sys);
    apb(1'b1, CTL, 8'h00);
    rd_in(CL, 8'd19, 8'd22);
    apb(1'b1, CL, 8'h00);
    ext_on <= 1'b1;
    apb(1'b1, CTL, 8'h05);
    repeat (384) @(posedge clk_sys);
    apb(1'b1, CTL, 8'h00);
    ext_on <= 1'b0;
    rd_in(CL, 8'd7, 8'd9);
  endtask

  task automatic t_capture;
    apb(1'b1, RLL, 8'haa);
    apb(1'b1, RLH, 8'hbb);
    apb(1'b1, CL, 8'h00);
    apb(1'b1, CH, 8'h00);
    apb(1'b1, CK, 8'h05);
    apb(1'b1, CTL, 8'h16);
    osc_low_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd_is(RLH, 8'h00);
    rd_in(RLL, 8'h01, 8'h20);
    rd_in(CTL, 8'h96, 8'hd6);
    irq_is(1'b1);
    osc_low_pin <= 1'b1;
    apb(1'b1, CTL, 8'h00);
    apb(1'b1, CK, 8'h07);
    apb(1'b1, CL, 8'h00);
    apb(1'b1, CH, 8'h40);
    apb(1'b1, CTL, 8'h1e);
    osc_low_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd_in(RLH, 8'h41, 8'h60);
    rd_in(RLL, 8'h01, 8'h20);
    osc_low_pin <= 1'b1;
    apb(1'b1, CTL, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset_map();
    t_bitop();
    t_reload16();
    t_split();
    t_rates();
    t_capture();
    give_verdict();
  end
endmodule
